//--- logic/ppcw_port.sv
`timescale 1ns/100ps
`include "ppcw_consts.svh"
module ppcw_port (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ctrlWrite,
  input wire logic [7:0] ctrlData,
  input wire logic [7:0] outReg,
  input wire logic [7:0] portPins,
  input wire logic opcodeFetchCycle_n,
  input wire logic ioRequest_n,
  input wire logic [7:0] fetchData,
  input wire logic priorityEnableIn,
  output ppcw_pkg::ppcw_mode_t mode,
  output logic [7:0] lineDirection,
  output logic intEnable,
  output logic intRequest,
  output logic priorityEnableOut,
  output logic [7:0] vectorOut,
  output logic vectorDrive
);
  import ppcw_pkg::*;
  logic [7:0] pinS1_q, pinS2_q;
  logic [7:0] fetchS1_q, fetchS2_q;
  logic m1S1_q, m1S2_q, iorqS1_q, iorqS2_q, ieiS1_q, ieiS2_q;
  logic [7:0] vec_q, dir_q, mask_q;
  ppcw_mode_t mode_q;
  ppcw_pend_t pend_q;
  logic ieArm_q, ie_q, andLogic_q, highLvl_q;
  logic cond_q, req_q, service_q, ieo_q, edSeen_q, m1Prev_q, drive_q, ackSeen_q;
  logic [7:0] lineVal;
  logic condNow, m1Active, ackNow, m1Rise;

  function automatic logic isCmd(input logic [7:0] cw, input logic [3:0] nib);
    return cw[0] && (cw[3:0] == nib);
  endfunction

  // two-flop sync of port pins and fetch data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinS1_q <= 8'h00;
      pinS2_q <= 8'h00;
      fetchS1_q <= 8'h00;
      fetchS2_q <= 8'h00;
    end else begin
      pinS1_q <= portPins;
      pinS2_q <= pinS1_q;
      fetchS1_q <= fetchData;
      fetchS2_q <= fetchS1_q;
    end
  end

  // two-flop sync of bus strobes and chain input
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      m1S1_q <= 1'b1;
      m1S2_q <= 1'b1;
      iorqS1_q <= 1'b1;
      iorqS2_q <= 1'b1;
      ieiS1_q <= 1'b0;
      ieiS2_q <= 1'b0;
    end else begin
      m1S1_q <= opcodeFetchCycle_n;
      m1S2_q <= m1S1_q;
      iorqS1_q <= ioRequest_n;
      iorqS2_q <= iorqS1_q;
      ieiS1_q <= priorityEnableIn;
      ieiS2_q <= ieiS1_q;
    end
  end

  assign m1Active = !m1S2_q;
  assign ackNow = m1Active && !iorqS2_q;
  assign m1Rise = m1Active == 1'b0 && m1Prev_q;

  // control word decode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vec_q <= `PPCW_RST_VEC;
      dir_q <= `PPCW_RST_DIR;
      mask_q <= `PPCW_RST_MASK;
      mode_q <= MODE_INPUT;
      pend_q <= PEND_NONE;
      andLogic_q <= 1'b0;
      highLvl_q <= 1'b0;
    end else if (ctrlWrite) begin
      case (pend_q)
        PEND_DIR: begin
          dir_q <= ctrlData;
          pend_q <= PEND_NONE;
        end
        PEND_MASK: begin
          mask_q <= ctrlData;
          pend_q <= PEND_NONE;
        end
        default: begin
          if (!ctrlData[0]) begin
            vec_q <= {ctrlData[7:1], 1'b0};
          end else if (isCmd(ctrlData, `PPCW_NIB_MODE)) begin
            mode_q <= ppcw_mode_t'(ctrlData[7:6]);
            if (ppcw_mode_t'(ctrlData[7:6]) == MODE_BITCTL) begin
              pend_q <= PEND_DIR;
            end
          end else if (isCmd(ctrlData, `PPCW_NIB_ICTL)) begin
            andLogic_q <= ctrlData[`PPCW_BIT_AND];
            highLvl_q <= ctrlData[`PPCW_BIT_HIGH];
            if (ctrlData[`PPCW_BIT_MFOL]) begin
              pend_q <= PEND_MASK;
            end
          end
        end
      endcase
    end
  end

  // interrupt enable arming and taking effect
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ieArm_q <= 1'b0;
      ie_q <= 1'b0;
      m1Prev_q <= 1'b0;
    end else begin
      m1Prev_q <= m1Active;
      if (ctrlWrite && pend_q == PEND_NONE &&
          (isCmd(ctrlData, `PPCW_NIB_ICTL) || isCmd(ctrlData, `PPCW_NIB_IEN))) begin
        ieArm_q <= ctrlData[`PPCW_BIT_IE];
        ie_q <= 1'b0;
      end else if (m1Rise && pend_q != PEND_MASK) begin
        if (!ackSeen_q) begin
          ie_q <= ieArm_q;
        end
      end
    end
  end

  // acknowledge seen within the current fetch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ackSeen_q <= 1'b0;
    end else if (ackNow) begin
      ackSeen_q <= 1'b1;
    end else if (m1Rise) begin
      ackSeen_q <= 1'b0;
    end
  end

  // logic function over masked lines, outputs use the output register
  always_comb begin
    lineVal = (pinS2_q & dir_q) | (outReg & ~dir_q);
    if (!highLvl_q) begin
      lineVal = ~lineVal;
    end
    if (andLogic_q) begin
      condNow = ((lineVal | mask_q) == 8'hff) && (mask_q != 8'hff);
    end else begin
      condNow = |(lineVal & ~mask_q);
    end
  end

  // request, service and chain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cond_q <= 1'b0;
      req_q <= 1'b0;
      service_q <= 1'b0;
      ieo_q <= 1'b0;
      edSeen_q <= 1'b0;
    end else begin
      if (!m1Active) begin
        cond_q <= condNow;
        if (mode_q == MODE_BITCTL && ie_q && condNow && !cond_q && !service_q) begin
          req_q <= 1'b1;
        end
        if (!ie_q || mode_q != MODE_BITCTL || service_q) begin
          req_q <= 1'b0;
        end
        ieo_q <= ieiS2_q && !service_q && !req_q;
      end else if (ackNow && req_q && ieiS2_q) begin
        service_q <= 1'b1;
      end
      if (m1Rise) begin
        edSeen_q <= fetchS2_q == `PPCW_OP_PREFIX;
        if (edSeen_q && fetchS2_q == `PPCW_OP_RETURN_FROM_INTERRUPT_OP && ieiS2_q && service_q) begin
          service_q <= 1'b0;
        end
      end
    end
  end

  // vector on the bus only for own acknowledge with priority
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= ackNow && req_q && ieiS2_q;
    end
  end

  // configuration outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= MODE_INPUT;
      lineDirection <= `PPCW_RST_DIR;
      vectorOut <= `PPCW_RST_VEC;
    end else begin
      mode <= mode_q;
      lineDirection <= dir_q;
      vectorOut <= vec_q;
    end
  end

  // interrupt and chain outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      intEnable <= 1'b0;
      intRequest <= 1'b0;
      priorityEnableOut <= 1'b0;
      vectorDrive <= 1'b0;
    end else begin
      intEnable <= ie_q;
      intRequest <= req_q;
      priorityEnableOut <= ieo_q;
      vectorDrive <= drive_q;
    end
  end
endmodule

//--- logic/ppcw_consts.svh
// Function
// - priority-enable out and request status never change while opcode fetch is active.
// - priority enable ripples through chain only while opcode fetch is inactive; it holds from opcode fetch through io request.
// - only highest-priority requesting port drives its vector during acknowledge.
// - no mask pending: enable interrupts at next opcode-fetch rising edge, not acknowledge.
// - mask follows: enable interrupts at first opcode-fetch edge after mask loaded.
// - word with bit 0 clear loads vector bits 7:1; vector bit 0 is zero.
// - low nibble 1111 selects mode from bits 7:6; bits 5:4 ignored.
// - after bit-control mode, next word is direction; one means input.
// - low nibble 0111: enable, and/or, high/low, mask follows in bits 7:4.
// - mask follows set: next word is mask; zero bits select monitored lines.
// - bit control, or logic, active high: any unmasked line high requests.
// - masked-in output lines are evaluated using the output register value.
// - low nibble 0011 changes only interrupt enable from bit 7.
// - bit-control interrupt only on false to true change of the logic result.
// - after acknowledge hold priority out low until return decoded with enable in high.
`ifndef PPCW_CONSTS_SVH
`define PPCW_CONSTS_SVH
`define PPCW_NIB_MODE 4'hf
`define PPCW_NIB_ICTL 4'h7
`define PPCW_NIB_IEN 4'h3
`define PPCW_BIT_IE 7
`define PPCW_BIT_AND 6
`define PPCW_BIT_HIGH 5
`define PPCW_BIT_MFOL 4
`define PPCW_RST_MASK 8'hff
`define PPCW_RST_DIR 8'hff
`define PPCW_RST_VEC 8'h00
`define PPCW_OP_PREFIX 8'hed
`define PPCW_OP_RETURN_FROM_INTERRUPT_OP 8'h4d
`endif

//--- logic/ppcw_pkg.sv
package ppcw_pkg;
  typedef enum logic [1:0] {
    MODE_OUTPUT,
    MODE_INPUT,
    MODE_BIDIR,
    MODE_BITCTL
  } ppcw_mode_t;
  typedef enum logic [1:0] {
    PEND_NONE,
    PEND_DIR,
    PEND_MASK
  } ppcw_pend_t;
endpackage

//--- tb/ppcw_port_sva.sv
`timescale 1ns/100ps
module ppcw_port_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ctrlWrite,
  input wire logic [7:0] ctrlData,
  input wire logic opcodeFetchCycle_n,
  input wire logic priorityEnableIn,
  input ppcw_pkg::ppcw_mode_t mode,
  input wire logic [7:0] lineDirection,
  input wire logic intEnable,
  input wire logic intRequest,
  input wire logic priorityEnableOut,
  input wire logic [7:0] vectorOut,
  input wire logic vectorDrive
);
  import ppcw_pkg::*;
  logic [1:0] pend_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      pend_q <= 2'h0;
    else if (ctrlWrite)
      pend_q <= (pend_q != 2'h0) ? 2'h0 : (ctrlData[3:0] == 4'hf && &ctrlData[7:6]) ? 2'h1 :
        {ctrlData[3:0] == 4'h7 && ctrlData[4], 1'b0};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_fetch_freeze: assert property (!opcodeFetchCycle_n [*6] |-> $stable(intRequest) && $stable(priorityEnableOut))
    else $error("request or priority changed in fetch");
  chk_vec_load: assert property (ctrlWrite && pend_q == 2'h0 && !ctrlData[0] |->
    ##2 vectorOut == {$past(ctrlData[7:1], 2), 1'b0}) else $error("vector not loaded");
  chk_vec_zero: assert property (!vectorOut[0])
    else $error("vector bit 0 set");
  chk_mode_sel: assert property (ctrlWrite && pend_q == 2'h0 && ctrlData[3:0] == 4'hf |->
    ##2 mode == ppcw_mode_t'($past(ctrlData[7:6], 2))) else $error("mode wrong");
  chk_dir_word: assert property (ctrlWrite && pend_q == 2'h1 |-> ##2 lineDirection == $past(ctrlData, 2))
    else $error("direction word wrong");
  chk_ien_clear: assert property (ctrlWrite && pend_q == 2'h0 && ctrlData == 8'h03 |=> ##1 !intEnable)
    else $error("enable not cleared");
  chk_en_mask: assert property ($rose(intEnable) |-> pend_q != 2'h2)
    else $error("enabled with mask pending");
  chk_pe_gate: assert property (!priorityEnableIn [*5] |-> !priorityEnableOut)
    else $error("priority out without priority in");
  chk_drive_gate: assert property (!priorityEnableIn [*5] |-> !vectorDrive)
    else $error("vector driven without priority");
endmodule
bind ppcw_port ppcw_port_sva u_sva (.clk(clk), .arst_n(arst_n), .ctrlWrite(ctrlWrite), .ctrlData(ctrlData),
  .opcodeFetchCycle_n(opcodeFetchCycle_n), .priorityEnableIn(priorityEnableIn), .mode(mode),
  .lineDirection(lineDirection), .intEnable(intEnable), .intRequest(intRequest),
  .priorityEnableOut(priorityEnableOut), .vectorOut(vectorOut), .vectorDrive(vectorDrive));

//--- tb/ppcw_host.sv
`timescale 1ns/100ps
module ppcw_host (
  input wire logic clk,
  output logic opcodeFetchCycle_n,
  output logic ioRequest_n,
  output logic [7:0] fetchData,
  output logic priorityEnableIn
);
  // one device only, inside the plain chain limit
  initial begin
    opcodeFetchCycle_n = 1'b1;
    ioRequest_n = 1'b1;
    fetchData = 8'h00;
    priorityEnableIn = 1'b1;
  end
  task automatic fetch(input logic [7:0] op, input logic ack);
    @(negedge clk);
    opcodeFetchCycle_n = 1'b0;
    fetchData = op;
    repeat (3) @(negedge clk);
    ioRequest_n = !ack;
    repeat (4) @(negedge clk);
    opcodeFetchCycle_n = 1'b1;
    ioRequest_n = 1'b1;
    repeat (3) @(negedge clk);
    fetchData = ~op;
  endtask
endmodule

//--- tb/ppcw_port_tb.sv
`timescale 1ns/100ps
module ppcw_port_tb;
  import ppcw_pkg::*;
  logic clk, arst_n, ctrlWrite, fetch_n, ioReq_n, peIn, intEnable, intRequest, priorityEnableOut, vectorDrive;
  logic [7:0] ctrlData, outReg, portPins, fetchByte, lineDirection, vectorOut;
  ppcw_mode_t mode;
  int fails, n_checks, cyc, nDrive;
  ppcw_host host (.clk(clk), .opcodeFetchCycle_n(fetch_n), .ioRequest_n(ioReq_n), .fetchData(fetchByte),
    .priorityEnableIn(peIn));
  ppcw_port DUT (.clk(clk), .arst_n(arst_n), .ctrlWrite(ctrlWrite), .ctrlData(ctrlData), .outReg(outReg),
    .portPins(portPins), .opcodeFetchCycle_n(fetch_n), .ioRequest_n(ioReq_n), .fetchData(fetchByte),
    .priorityEnableIn(peIn), .mode(mode), .lineDirection(lineDirection), .intEnable(intEnable),
    .intRequest(intRequest), .priorityEnableOut(priorityEnableOut), .vectorOut(vectorOut), .vectorDrive(vectorDrive));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task results;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      fails++;
      results;
    end
  end
  always @(negedge clk) begin
    if (vectorDrive === 1'b1) begin
      nDrive++;
    end
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] d);
    @(negedge clk);
    ctrlWrite = 1'b1;
    ctrlData = d;
    @(negedge clk);
    ctrlWrite = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    arst_n = 1'b0;
    ctrlWrite = 1'b0;
    ctrlData = 8'h00;
    outReg = 8'h00;
    portPins = 8'h00;
    settle(10);
    arst_n = 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr({m[1:0], 2'h2, 4'hf});
      chk({6'h0, mode}, {6'h0, m[1:0]});
    end
    wr(8'h0f);
    chk(lineDirection, 8'h0f);
    $display("test modes done");
    wr(8'hac);
    chk(vectorOut, 8'hac);
    wr(8'hb7);
    host.fetch(8'h00, 1'b0);
    settle(4);
    chk({7'h0, intEnable}, 8'h00);
    wr(8'h07);
    host.fetch(8'h00, 1'b0);
    settle(4);
    chk({7'h0, intEnable}, 8'h01);
    portPins = 8'h08;
    settle(6);
    chk({7'h0, intRequest}, 8'h01);
    chk(nDrive[7:0], 8'h00);
    $display("test interrupt setup done");
    host.fetch(8'h00, 1'b1);
    settle(4);
    chk({6'h0, intRequest, priorityEnableOut}, 8'h00);
    chk({7'h0, nDrive != 0}, 8'h01);
    host.fetch(8'hed, 1'b0);
    host.fetch(8'h4d, 1'b0);
    settle(4);
    chk({7'h0, priorityEnableOut}, 8'h01);
    portPins = 8'h00;
    settle(6);
    outReg = 8'h80;
    settle(6);
    chk({7'h0, intRequest}, 8'h01);
    $display("test service done");
    wr(8'h03);
    chk({7'h0, intEnable}, 8'h00);
    wr(8'h83);
    host.fetch(8'h00, 1'b1);
    settle(4);
    chk({7'h0, intEnable}, 8'h00);
    host.fetch(8'h00, 1'b0);
    settle(4);
    chk({7'h0, intEnable}, 8'h01);
    host.priorityEnableIn = 1'b0;
    settle(8);
    chk({6'h0, vectorDrive, priorityEnableOut}, 8'h00);
    host.priorityEnableIn = 1'b1;
    outReg = 8'h00;
    settle(6);
    outReg = 8'h80;
    settle(6);
    chk({7'h0, intRequest}, 8'h01);
    $display("test enable done");
    results;
  end
endmodule
